//--- rtl/vmeirq_ctrl.sv
// controller end: handler for levels five to seven and logic trigger
`timescale 1ns/1ps
`default_nettype none
`include "vmeirq_defs.svh"
// ----------------------------------------
// notes for integrators
// ----------------------------------------
// one acknowledge cycle runs at a time; a level seven request always
// goes ahead of six and five, so a stuck level seven holder starves
// the lower levels
// the gap after each cycle is the rate limit shared with local
// interrupt sources; raising it slows every source alike
// an add-in module that never answers is dropped after the hold
// count runs out, so a missing id costs a few cycles, not a hang
// the table holds NSRC sources; ids beyond it are acknowledged and
// reported as processed but can never be scheduled
// clkEn low freezes every register; a mask request seen meanwhile
// is lost, while a held interrupt request simply waits
module vmeirq_ctrl #(
	parameter int NSRC = `VMEIRQ_NSRC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic [NSRC-1:0] cfgEnable,
	input wire logic runMode,
	input wire logic maskReq,
	input wire logic maskSet,
	input wire logic [7:0] maskSpace,
	input wire logic [7:0] maskOffset,
	output logic trigger,
	output logic [7:0] triggerId,
	output logic processed,
	output logic [NSRC-1:0] maskState,
	vmeirq_if.ctrl bus
);
	// sequencer state: phase, level under service, timeout and gap
	// counts; all of it moves only while clkEn is high
	vmeirq_pkg::vmeirq_state_t state;
	vmeirq_pkg::vmeirq_state_t next_state;
	logic [2:0] level;
	logic [2:0] next_level;
	logic [3:0] hold;
	logic [3:0] next_hold;
	logic [7:0] gap;
	logic [7:0] next_gap;
	// run-time masks and the run edge detector
	logic [NSRC-1:0] mask;
	logic [NSRC-1:0] next_mask;
	logic runPrev;
	logic next_runPrev;
	// registered results of the last acknowledge
	logic trig;
	logic next_trig;
	logic proc;
	logic next_proc;
	logic [7:0] tid;
	logic [7:0] next_tid;
	logic idOk;
	// source index width follows the table depth
	localparam int IDX_W = (NSRC > 1) ? $clog2(NSRC) : 1;
	logic [IDX_W-1:0] ackIdx;
	logic [IDX_W-1:0] reqIdx;
	// ----------------------------------------
	// source id decode
	// ----------------------------------------
	// ids past the table end are answered but never scheduled
	assign idOk = bus.idData < 8'(NSRC);
	assign ackIdx = bus.idData[IDX_W-1:0];
	assign reqIdx = maskOffset[IDX_W-1:0];
	// ----------------------------------------
	// acknowledge sequencer and scheduling
	// ----------------------------------------
	// highest level first among the three handled levels; the hold
	// count bounds a cycle that nobody answers, and the gap count
	// spaces consecutive cycles
	always_comb begin
		next_state = state;
		next_level = level;
		next_hold = hold;
		next_gap = (gap != 8'h00) ? gap - 8'h01 : gap;
		next_trig = 1'b0;
		next_proc = 1'b0;
		next_tid = tid;
		unique case (state)
			vmeirq_pkg::VMEIRQ_IDLE: begin
				// gap throttles service like local interrupts
				if (gap == 8'h00) begin
					if (bus.irqReq[7]) begin
						next_level = `VMEIRQ_LEVEL_HI;
						next_state = vmeirq_pkg::VMEIRQ_ACK;
					end else if (bus.irqReq[6]) begin
						next_level = `VMEIRQ_LEVEL_MID;
						next_state = vmeirq_pkg::VMEIRQ_ACK;
					end else if (bus.irqReq[5]) begin
						next_level = `VMEIRQ_LEVEL_LO;
						next_state = vmeirq_pkg::VMEIRQ_ACK;
					end
					next_hold = `VMEIRQ_ACK_HOLD;
				end
			end
			vmeirq_pkg::VMEIRQ_ACK: begin
				if (bus.idValid) begin
					next_proc = 1'b1;
					next_tid = bus.idData;
					// configured-off or masked sources are counted only
					if (idOk && cfgEnable[ackIdx]
						&& !mask[ackIdx]) begin
						next_trig = 1'b1;
					end
					next_state = vmeirq_pkg::VMEIRQ_DONE;
				end else if (hold == 4'h0) begin
					// nobody answered; drop the cycle
					// a request still up is tried again after the gap
					next_state = vmeirq_pkg::VMEIRQ_DONE;
				end else begin
					next_hold = hold - 4'h1;
				end
			end
			vmeirq_pkg::VMEIRQ_DONE: begin
				// a still-held request is sampled anew from idle
				next_state = vmeirq_pkg::VMEIRQ_IDLE;
				next_gap = `VMEIRQ_MIN_GAP;
			end
			default: begin
				next_state = vmeirq_pkg::VMEIRQ_IDLE;
			end
		endcase
	end
	// ----------------------------------------
	// run-time mask table
	// ----------------------------------------
	// a refused request leaves the table alone; a disabled source keeps its mask
	// until a run edge clears it, so an unmask aimed at it changes nothing
	always_comb begin
		next_runPrev = runMode;
		next_mask = mask;
		if (maskReq && maskSpace == `VMEIRQ_ID_SPACE_CODE
			&& maskOffset < 8'(NSRC)
			&& cfgEnable[reqIdx]) begin
			next_mask[reqIdx] = maskSet;
		end
		// entering run wins over a mask request in the same cycle
		if (runMode && !runPrev) begin
			next_mask = '0;
		end
	end
	// ----------------------------------------
	// state registers
	// ----------------------------------------
	// sequencer registers; clkEn low freezes the cycle in place
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= vmeirq_pkg::VMEIRQ_IDLE;
			level <= 3'h0;
			hold <= 4'h0;
			gap <= 8'h00;
			trig <= 1'b0;
			proc <= 1'b0;
			tid <= 8'h00;
		end else if (clkEn) begin
			state <= next_state;
			level <= next_level;
			hold <= next_hold;
			gap <= next_gap;
			trig <= next_trig;
			proc <= next_proc;
			tid <= next_tid;
		end
	end
	// mask registers; a run level held through reset still counts as a
	// fresh stop to run edge, which only clears masks that are clear
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mask <= '0;
			runPrev <= 1'b0;
		end else if (clkEn) begin
			mask <= next_mask;
			runPrev <= next_runPrev;
		end
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// the acknowledge strobe is a decode of the state register
	assign bus.ackLevel = level;
	assign bus.ackIn = (state == vmeirq_pkg::VMEIRQ_ACK);
	// results come straight from flip-flops, one cycle per pulse
	assign trigger = trig;
	assign processed = proc;
	assign triggerId = tid;
	assign maskState = mask;
endmodule : vmeirq_ctrl
`default_nettype wire

//--- rtl/vmeirq_defs.svh
// constants for the bus interrupt trigger block
`ifndef VMEIRQ_DEFS_SVH
`define VMEIRQ_DEFS_SVH
`define VMEIRQ_LEVEL_LO 3'h5
`define VMEIRQ_LEVEL_MID 3'h6
`define VMEIRQ_LEVEL_HI 3'h7
`define VMEIRQ_ID_SPACE_CODE 8'h11
`define VMEIRQ_ID_W 8
`define VMEIRQ_NSRC 16
`define VMEIRQ_ACK_HOLD 4'h2
`define VMEIRQ_MIN_GAP 8'h04
`endif

//--- rtl/vmeirq_if.sv
// backplane interrupt link between controller and add-in module
`timescale 1ns/1ps
`default_nettype none
interface vmeirq_if;
	logic [7:1] irqReq;
	logic [2:0] ackLevel;
	logic ackIn;
	logic ackOut;
	logic [7:0] idData;
	logic idValid;
	modport ctrl (input irqReq, output ackLevel, output ackIn,
		input ackOut, input idData, input idValid);
	modport module_end (output irqReq, input ackLevel, input ackIn,
		output ackOut, output idData, output idValid);
endinterface : vmeirq_if
`default_nettype wire

//--- rtl/vmeirq_module.sv
// add-in module end: requests on the middle level and answers acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "vmeirq_defs.svh"
module vmeirq_module #(
	parameter logic [7:0] SRC_ID = 8'h03
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic raise,
	output logic pending,
	vmeirq_if.module_end bus
);
	logic req;
	logic next_req;
	// ----------------------------------------
	// request latch
	// ----------------------------------------
	// never drives an acknowledge itself; only answers one
	always_comb begin
		next_req = req;
		if (bus.ackIn && bus.ackLevel == `VMEIRQ_LEVEL_MID && req) begin
			next_req = 1'b0;
		end
		if (raise) begin
			next_req = 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			req <= 1'b0;
		end else if (clkEn) begin
			req <= next_req;
		end
	end
	// only level six used by add-in modules
	assign bus.irqReq = {1'b0, req, 5'h00};
	// pass acknowledge on unless it is ours to answer; passing the chain
	// lets this module sit in any slot
	assign bus.ackOut = bus.ackIn && !bus.idValid;
	// answer only an acknowledge aimed at the middle level
	assign bus.idValid = bus.ackIn && req
		&& bus.ackLevel == `VMEIRQ_LEVEL_MID;
	assign bus.idData = req ? SRC_ID : 8'h00;
	assign pending = req;
endmodule : vmeirq_module
`default_nettype wire

//--- rtl/vmeirq_pkg.sv
// types used by the controller end of the bus interrupt trigger block
package vmeirq_pkg;
	typedef enum logic [1:0] {
		VMEIRQ_IDLE = 2'b00,
		VMEIRQ_ACK = 2'b01,
		VMEIRQ_DONE = 2'b11
	} vmeirq_state_t;
endpackage : vmeirq_pkg

//--- tb/test_vme_irq_logic_trigger.sv
// self-checking bench for the controller and module pair
`timescale 1ns/1ps
`default_nettype none
module test_vme_irq_logic_trigger;
	logic clock = 1'b0, sys_rst = 1'b1, runMode = 1'b0, raise = 1'b0;
	logic clkEn = 1'b1;
	logic maskReq = 1'b0, maskSet = 1'b0, trigger, processed, pending;
	logic [7:0] maskSpace = 8'h11, maskOffset = 8'h00, triggerId;
	logic [15:0] cfgEnable = 16'hFFFF, maskState;
	int err_total = 0, num_checks = 0;
	vmeirq_if bus ();
	vmeirq_ctrl u_vmeirq_ctrl (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
		.cfgEnable(cfgEnable), .runMode(runMode), .maskReq(maskReq),
		.maskSet(maskSet), .maskSpace(maskSpace), .maskOffset(maskOffset),
		.trigger(trigger), .triggerId(triggerId), .processed(processed),
		.maskState(maskState), .bus(bus.ctrl));
	vmeirq_module u_vmeirq_module (.clock(clock), .sys_rst(sys_rst),
		.clkEn(clkEn), .raise(raise), .pending(pending), .bus(bus.module_end));
	vmeirq_properties u_vmeirq_properties (.clock(clock), .sys_rst(sys_rst),
		.irqReq(bus.irqReq), .ackLevel(bus.ackLevel), .ackIn(bus.ackIn),
		.ackOut(bus.ackOut), .idData(bus.idData), .idValid(bus.idValid));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	always #25 clock = ~clock;
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (!ok) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic msk(input logic set, input logic [7:0] sp,
		input logic [7:0] off);
		@(posedge clock) maskReq <= 1'b1;
		maskSet <= set;
		maskSpace <= sp;
		maskOffset <= off;
		@(posedge clock) maskReq <= 1'b0;
		@(negedge clock);
	endtask : msk
	// bounded wait: a lost acknowledge ends the run instead of hanging it
	task automatic svc(input logic exp);
		int n;
		@(posedge clock) raise <= 1'b1;
		@(posedge clock) raise <= 1'b0;
		for (n = 0; n < 40 && processed !== 1'b1; n++) @(negedge clock);
		chk(processed === 1'b1 && trigger === exp, "service");
		if (processed !== 1'b1) report_and_stop();
		chk(triggerId === 8'h03, "id");
		chk(pending === 1'b0, "request held");
	endtask : svc
	task automatic t_repeat;
		svc(1'b1);
		svc(1'b1);
	endtask : t_repeat
	task automatic t_mask;
		msk(1'b1, 8'h11, 8'h03);
		chk(maskState === 16'h0008, "mask");
		msk(1'b0, 8'h12, 8'h03);
		msk(1'b1, 8'h11, 8'h10);
		chk(maskState === 16'h0008, "refused");
		svc(1'b0);
		msk(1'b0, 8'h11, 8'h03);
		chk(maskState === 16'h0000, "unmask");
	endtask : t_mask
	// clock enable low must hold every register, mask requests included
	task automatic t_freeze;
		@(posedge clock) clkEn <= 1'b0;
		msk(1'b1, 8'h11, 8'h05);
		chk(maskState === 16'h0000, "frozen");
		@(posedge clock) clkEn <= 1'b1;
		msk(1'b1, 8'h11, 8'h05);
		chk(maskState === 16'h0020, "thawed");
		msk(1'b0, 8'h11, 8'h05);
		chk(maskState === 16'h0000, "unmask after thaw");
	endtask : t_freeze
	// source 3 masked, then disabled: unmask refused, run clears,
	// and only the configuration keeps it from triggering
	task automatic t_cfg;
		msk(1'b1, 8'h11, 8'h03);
		@(posedge clock) cfgEnable <= 16'hFFF7;
		msk(1'b0, 8'h11, 8'h03);
		chk(maskState[3] === 1'b1, "unmask of off source");
		@(posedge clock) runMode <= 1'b1;
		repeat (2) @(negedge clock);
		chk(maskState === 16'h0000, "run clears");
		svc(1'b0);
		@(posedge clock) cfgEnable <= 16'hFFFF;
		svc(1'b1);
	endtask : t_cfg
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	// main sequence after five reset cycles
	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		t_repeat();
		t_mask();
		t_freeze();
		t_cfg();
		report_and_stop();
	end
endmodule : test_vme_irq_logic_trigger
`default_nettype wire

//--- tb/vmeirq_properties.sv
// concurrent checks on the backplane interrupt link
`timescale 1ns/1ps
`default_nettype none
module vmeirq_properties (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:1] irqReq,
	input wire logic [2:0] ackLevel,
	input wire logic ackIn,
	input wire logic ackOut,
	input wire logic [7:0] idData,
	input wire logic idValid
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// acknowledge cycle shape and spacing
	// ----------------------------------------
	AST_LEVEL: assert property (
		ackIn |-> ackLevel inside {3'h5, 3'h6, 3'h7})
		else $error("ack on foreign level");
	AST_CAUSE: assert property (
		$rose(ackIn) |-> $past(irqReq[7:5]) != 3'h0)
		else $error("ack without request");
	AST_BOUND: assert property ($rose(ackIn) |-> ##[1:3] !ackIn)
		else $error("ack cycle too long");
	AST_ID: assert property (idValid |-> ackIn && ackLevel == 3'h6)
		else $error("id outside ack");
	AST_RELEASE: assert property (ackIn && idValid |=> !irqReq[6])
		else $error("request held after ack");
	// rate limit keeps a stuck request from taking back-to-back acknowledge cycles
	AST_GAP: assert property ($fell(ackIn) |-> !ackIn [*4])
		else $error("service gap too short");
	AST_AGAIN: assert property (
		irqReq[6] && !ackIn |-> ##[1:12] ackIn)
		else $error("request not serviced");
	AST_CHAIN: assert property (idValid |-> !ackOut)
		else $error("chain passed while answering");
	cover property (idValid && idData == 8'h03);
	cover property ($fell(ackIn) ##[1:12] $rose(ackIn));
	cover property (ackIn && ackLevel == 3'h6);
endmodule : vmeirq_properties
`default_nettype wire
